// ### xdmm_pkg.sv
// Package of constants and carrier types for the data memory mapping block
package xdmm_pkg;
  // ==========================================================
  // Address map
  localparam logic [15:0] PROG_TOP = 16'hFFFF;
  localparam logic [4:0] SVC_BLOCKS_MAX = 5'h10;
  localparam int BLOCK_SHIFT = 8;
  localparam logic [15:0] XRAM_TOP = 16'h03FF;
  localparam logic [7:0] PAGE_INT_MAX = 8'h03;
  localparam logic [7:0] LOW_DIRECT_TOP = 8'h7F;
  localparam logic [7:0] WORK_REG_TOP = 8'h1F;
  localparam logic [7:0] BIT_AREA_TOP = 8'h2F;
  localparam int XRAM_WORDS = 1024;
  localparam int SCRATCH_WORDS = 256;
  // ==========================================================
  // Register byte addresses; the page register sits at four times its index
  localparam logic [7:0] PAGE_SEL_IDX = 8'h86;
  localparam logic [9:0] PAGE_SEL_OFF = {PAGE_SEL_IDX, 2'h0};
  localparam logic [9:0] CTRL_OFF = 10'h090;
  localparam logic [9:0] STATUS_OFF = 10'h094;
  localparam logic [7:0] PAGE_SEL_RST = 8'h00;
  // Control bit positions
  localparam int CTRL_EXT_EN_BIT = 0;
  localparam int CTRL_PTR_SEL_BIT = 1;
  localparam int CTRL_BLOCKS_LSB = 8;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Carrier types
  typedef enum logic [1:0] {
    XDMM_AREA_WORKREG = 2'h0,
    XDMM_AREA_BIT = 2'h1,
    XDMM_AREA_GENERAL = 2'h3,
    XDMM_AREA_UPPER = 2'h2
  } xdmm_area_t;
  typedef struct packed {
    logic req;
    logic write;
    logic viaPointer;
    logic [7:0] lowReg;
    logic [7:0] wdata;
  } xdmm_xreq_t;
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } xdmm_xrsp_t;
  typedef struct packed {
    logic req;
    logic write;
    logic indirect;
    logic [7:0] addr;
    logic [7:0] wdata;
  } xdmm_ireq_t;
endpackage : xdmm_pkg

// ### xdmm_ram.sv
// Single-port byte RAM built from flip-flops
`timescale 1ns/1ps
module xdmm_ram #(
  parameter int WORDS = 1024,
  parameter int AW = 10
) (
  // Clock
  input wire logic core_clk,
  // Access
  input wire logic wrEn,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [WORDS];

  // Write port and registered read
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : xdmm_ram

// ### xdmm_top.sv
// Memory map and external-data address routing block
// Contract
// - Decode full 64K flash program space
// - Service region up to 4K at top
// - Region sized as N 256-byte blocks, 0..16
// - N zero means no reserved region
// - Region runs downward from top by N*256
// - 256 internal bytes plus 1K expanded RAM
// - 00H-7FH direct and indirect reachable
// - Work regs, bit area, general areas
// - 80H-FFH indirect only
// - 0000H-03FFH maps to expanded RAM; the code sends every move off-chip when enable is 1
// - Pointer moves above 03FFH go off-chip
// - Page register gives high byte, resets 00H
// - Enable 0, page 0..3: internal RAM
// - Enable 0, page 4..255: page on port
// - Enable 1: port latch gives high byte
// - Pointer moves use selected data pointer
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module xdmm_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // AXI4-Lite slave
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core pointers and port latch
  input wire logic [15:0] dataPointer0,
  input wire logic [15:0] dataPointer1,
  input wire logic [7:0] highPortLatch,
  // Program fetch
  input wire logic [15:0] progAddr,
  output logic progServiceHit,
  // Scratchpad access
  input wire xdmm_pkg::xdmm_ireq_t iReq,
  output logic [7:0] iRdata,
  output logic iIllegal,
  output xdmm_pkg::xdmm_area_t iArea,
  // External-data move
  input wire xdmm_pkg::xdmm_xreq_t xReq,
  output xdmm_pkg::xdmm_xrsp_t xRsp,
  // Off-chip memory
  output logic [7:0] highAddressPort,
  output logic [7:0] extLowAddr,
  output logic extRdStrobe,
  output logic extWrStrobe,
  output logic [7:0] extWdata,
  input wire logic [7:0] extRdata
);
  // ==========================================================
  // Register file
  logic [7:0] xramPageSelect_q;
  logic extMemEnable_q;
  logic ptrSelect_q;
  logic [4:0] svcBlocks_q;
  logic awPend_q;
  logic wPend_q;
  logic [9:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic extCount_q;
  logic [7:0] lastPage_q;

  assign s_axi_awready = !awPend_q && !s_axi_bvalid;
  assign s_axi_wready = !wPend_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Capture address and data in either order
  always_ff @(posedge core_clk) begin
    if (srst) begin
      awPend_q <= 1'b0;
      wPend_q <= 1'b0;
      awAddr_q <= 10'h000;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else if (awPend_q && wPend_q) begin
      awPend_q <= 1'b0;
      wPend_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awPend_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wPend_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
    end
  end

  logic wrFire;
  logic wrPage;
  logic wrCtrl;
  assign wrFire = awPend_q && wPend_q;
  assign wrPage = wrFire && awAddr_q == xdmm_pkg::PAGE_SEL_OFF && wStrb_q[0];
  assign wrCtrl = wrFire && awAddr_q == xdmm_pkg::CTRL_OFF;

  // Write response
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= xdmm_pkg::RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awAddr_q == xdmm_pkg::PAGE_SEL_OFF || awAddr_q == xdmm_pkg::CTRL_OFF) ?
                     xdmm_pkg::RESP_OKAY : xdmm_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Page register, resets to page zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      xramPageSelect_q <= xdmm_pkg::PAGE_SEL_RST;
    end else if (wrPage) begin
      xramPageSelect_q <= wData_q[7:0];
    end
  end

  // Control bits; block count is written over the register port, counts above 16 are ignored, and reset clears it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      extMemEnable_q <= 1'b0;
      ptrSelect_q <= 1'b0;
      svcBlocks_q <= 5'h00;
    end else if (wrCtrl) begin
      if (wStrb_q[0]) begin
        extMemEnable_q <= wData_q[xdmm_pkg::CTRL_EXT_EN_BIT];
        ptrSelect_q <= wData_q[xdmm_pkg::CTRL_PTR_SEL_BIT];
      end
      if (wStrb_q[1] && wData_q[xdmm_pkg::CTRL_BLOCKS_LSB +: 5] <= xdmm_pkg::SVC_BLOCKS_MAX) begin
        svcBlocks_q <= wData_q[xdmm_pkg::CTRL_BLOCKS_LSB +: 5];
      end
    end
  end

  // Read channel
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    case (s_axi_araddr)
      xdmm_pkg::PAGE_SEL_OFF: rdMux[7:0] = xramPageSelect_q;
      xdmm_pkg::CTRL_OFF: begin
        rdMux[xdmm_pkg::CTRL_EXT_EN_BIT] = extMemEnable_q;
        rdMux[xdmm_pkg::CTRL_PTR_SEL_BIT] = ptrSelect_q;
        rdMux[xdmm_pkg::CTRL_BLOCKS_LSB +: 5] = svcBlocks_q;
      end
      xdmm_pkg::STATUS_OFF: begin
        rdMux[0] = extCount_q;
        rdMux[15:8] = lastPage_q;
      end
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= xdmm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= (s_axi_araddr == xdmm_pkg::PAGE_SEL_OFF || s_axi_araddr == xdmm_pkg::CTRL_OFF ||
                      s_axi_araddr == xdmm_pkg::STATUS_OFF) ? xdmm_pkg::RESP_OKAY : xdmm_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Program space decode
  logic [15:0] svcBase;
  assign svcBase = 16'(17'h10000 - (17'(svcBlocks_q) << xdmm_pkg::BLOCK_SHIFT));
  // Zero blocks leaves the whole 64K as program memory
  assign progServiceHit = (svcBlocks_q != 5'h00) && (progAddr >= svcBase) && (progAddr <= xdmm_pkg::PROG_TOP);

  // ==========================================================
  // Scratchpad 256 bytes
  logic [7:0] iRdRaw;
  assign iIllegal = iReq.req && !iReq.indirect && (iReq.addr > xdmm_pkg::LOW_DIRECT_TOP);

  // Area classification of the scratchpad address
  always_comb begin
    if (iReq.addr <= xdmm_pkg::WORK_REG_TOP) begin
      iArea = xdmm_pkg::XDMM_AREA_WORKREG;
    end else if (iReq.addr <= xdmm_pkg::BIT_AREA_TOP) begin
      iArea = xdmm_pkg::XDMM_AREA_BIT;
    end else if (iReq.addr <= xdmm_pkg::LOW_DIRECT_TOP) begin
      iArea = xdmm_pkg::XDMM_AREA_GENERAL;
    end else begin
      iArea = xdmm_pkg::XDMM_AREA_UPPER;
    end
  end

  xdmm_ram #(
    .WORDS(xdmm_pkg::SCRATCH_WORDS),
    .AW(8)
  ) scratchRam (
    .core_clk(core_clk),
    .wrEn(iReq.req && iReq.write && !iIllegal),
    .addr(iReq.addr),
    .wdata(iReq.wdata),
    .rdata(iRdRaw)
  );
  assign iRdata = iRdRaw;

  // ==========================================================
  // External-data move routing
  logic [15:0] selPointer;
  logic [15:0] xAddr;
  logic goExternal;
  logic [7:0] xRamRd;
  assign selPointer = ptrSelect_q ? dataPointer1 : dataPointer0;

  // Address and route selection
  always_comb begin
    if (xReq.viaPointer) begin
      xAddr = selPointer;
      goExternal = extMemEnable_q || (selPointer > xdmm_pkg::XRAM_TOP);
    end else if (extMemEnable_q) begin
      xAddr = {highPortLatch, xReq.lowReg};
      goExternal = 1'b1;
    end else begin
      xAddr = {xramPageSelect_q, xReq.lowReg};
      goExternal = xramPageSelect_q > xdmm_pkg::PAGE_INT_MAX;
    end
  end

  xdmm_ram #(
    .WORDS(xdmm_pkg::XRAM_WORDS),
    .AW(10)
  ) expandRam (
    .core_clk(core_clk),
    .wrEn(xReq.req && xReq.write && !goExternal),
    .addr(xAddr[9:0]),
    .wdata(xReq.wdata),
    .rdata(xRamRd)
  );

  // Off-chip strobes and address, registered
  always_ff @(posedge core_clk) begin
    if (srst) begin
      highAddressPort <= 8'h00;
      extLowAddr <= 8'h00;
      extRdStrobe <= 1'b0;
      extWrStrobe <= 1'b0;
      extWdata <= 8'h00;
    end else begin
      extRdStrobe <= xReq.req && goExternal && !xReq.write;
      extWrStrobe <= xReq.req && goExternal && xReq.write;
      if (xReq.req && goExternal) begin
        highAddressPort <= xAddr[15:8];
        extLowAddr <= xAddr[7:0];
        extWdata <= xReq.wdata;
      end
    end
  end

  // Answer one cycle after the request
  logic xAck_q;
  logic ackExt_q;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      xAck_q <= 1'b0;
      ackExt_q <= 1'b0;
    end else begin
      xAck_q <= xReq.req;
      ackExt_q <= goExternal;
    end
  end
  // One driver for the whole response carrier
  assign xRsp = '{ack: xAck_q, rdata: ackExt_q ? extRdata : xRamRd};

  // Status: last route and page
  always_ff @(posedge core_clk) begin
    if (srst) begin
      extCount_q <= 1'b0;
      lastPage_q <= 8'h00;
    end else if (xReq.req) begin
      extCount_q <= goExternal;
      lastPage_q <= xAddr[15:8];
    end
  end

  // ==========================================================
  // Checks
  pageReset_a: assert property (@(posedge core_clk) srst |=> xramPageSelect_q == 8'h00)
    else $error("page register not cleared by reset");
  // Register-indirect moves
  lowPageInt_a: assert property (@(posedge core_clk) disable iff (srst)
    (xReq.req && !xReq.viaPointer && !extMemEnable_q && xramPageSelect_q <= xdmm_pkg::PAGE_INT_MAX)
    |=> !extRdStrobe && !extWrStrobe)
    else $error("low page went off-chip");
  highPageExt_a: assert property (@(posedge core_clk) disable iff (srst)
    (xReq.req && !xReq.viaPointer && !extMemEnable_q && xramPageSelect_q > xdmm_pkg::PAGE_INT_MAX)
    |=> (extRdStrobe || extWrStrobe) && highAddressPort == $past(xramPageSelect_q))
    else $error("high page not driven on port");
  latchHigh_a: assert property (@(posedge core_clk) disable iff (srst)
    (xReq.req && !xReq.viaPointer && extMemEnable_q) |=> highAddressPort == $past(highPortLatch))
    else $error("port latch not used as high byte");
  // Pointer moves, and the acknowledge of every move
  ptrAbove_a: assert property (@(posedge core_clk) disable iff (srst)
    (xReq.req && xReq.viaPointer && selPointer > xdmm_pkg::XRAM_TOP) |=> extRdStrobe || extWrStrobe)
    else $error("pointer above 1K stayed internal");
  ptrInternal_a: assert property (@(posedge core_clk) disable iff (srst)
    (xReq.req && xReq.viaPointer && !extMemEnable_q && selPointer <= xdmm_pkg::XRAM_TOP)
    |=> !extRdStrobe && !extWrStrobe)
    else $error("low pointer went off-chip");
  ptrSelect_a: assert property (@(posedge core_clk) disable iff (srst)
    (xReq.req && xReq.viaPointer && goExternal)
    |=> {highAddressPort, extLowAddr} == $past(selPointer))
    else $error("wrong data pointer used");
  moveAck_a: assert property (@(posedge core_clk) disable iff (srst)
    xReq.req |=> xRsp.ack)
    else $error("move not answered next cycle");
  // Program space and scratchpad
  svcRegion_a: assert property (@(posedge core_clk) disable iff (srst)
    progServiceHit |-> svcBlocks_q != 5'h00 && progAddr >= 16'hF000)
    else $error("service region decode wrong");
  oneBlock_a: assert property (@(posedge core_clk) disable iff (srst)
    (svcBlocks_q == 5'h01) |-> progServiceHit == (progAddr[15:8] == 8'hFF))
    else $error("single block region not at top page");
  directUpper_a: assert property (@(posedge core_clk) disable iff (srst)
    (iReq.req && !iReq.indirect && iReq.addr[7]) |-> iIllegal)
    else $error("direct upper access not flagged");
  upperArea_a: assert property (@(posedge core_clk) disable iff (srst)
    iReq.addr[7] |-> iArea == xdmm_pkg::XDMM_AREA_UPPER)
    else $error("upper address not classed as upper area");
endmodule : xdmm_top

// ### xdmm_ext_mem.sv
// Behavioural off-chip data memory on the port bus
`timescale 1ns/1ps
module xdmm_ext_mem (
  // Clock
  input wire logic core_clk,
  // Port bus
  input wire logic [7:0] highAddressPort,
  input wire logic [7:0] extLowAddr,
  input wire logic extRdStrobe,
  input wire logic extWrStrobe,
  input wire logic [7:0] extWdata,
  output logic [7:0] extRdata
);
  logic [7:0] mem [65536];
  logic [7:0] junk_q = 8'h5A;
  // ==========================================================
  // Storage
  initial foreach (mem[i]) mem[i] = 8'h00;
  // Store on write strobe, alternate the idle bus between 5AH and A6H instead of driving stale data
  always @(posedge core_clk) begin
    if (extWrStrobe) mem[{highAddressPort, extLowAddr}] <= extWdata;
    junk_q <= ~junk_q + 8'h01;
  end
  // Read data only while the read strobe is up
  assign extRdata = extRdStrobe ? mem[{highAddressPort, extLowAddr}] : junk_q;
endmodule : xdmm_ext_mem

// ### xdmm_top_test.sv
// Self-checking bench for the data memory mapping block
`timescale 1ns/1ps
module xdmm_top_test;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [9:0] awAddr = 10'h000, arAddr = 10'h000;
  logic [7:0] latch = 8'h00, pg;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0, en, ptrSel;
  logic [31:0] wData = 32'h0, rData;
  logic awReady, wReady, bValid, arReady, rValid, progHit, iIll, exRs, exWs;
  logic [1:0] bResp, rResp;
  logic [15:0] dp0 = 16'h0, dp1 = 16'h0, progAddr = 16'h0;
  logic [7:0] iRd, hiPort, loAddr, exWd, exRd;
  logic [7:0] sa [8] = '{8'h00, 8'h1F, 8'h20, 8'h2F, 8'h30, 8'h7F, 8'h80, 8'hFF};
  xdmm_pkg::xdmm_area_t iArea;
  xdmm_pkg::xdmm_ireq_t iReq = '0;
  xdmm_pkg::xdmm_xreq_t xReq = '0;
  xdmm_pkg::xdmm_xrsp_t xRsp;
  int errors = 0, total_checks = 0, n, nb, b, m;
  int sp [256];
  int xm [1024];
  int em [int];
  // ==========================================================
  // Clock, design and far-side memory
  always #5 core_clk = ~core_clk;
  xdmm_top dut (.core_clk(core_clk), .srst(srst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .dataPointer0(dp0),
    .dataPointer1(dp1), .highPortLatch(latch), .progAddr(progAddr), .progServiceHit(progHit),
    .iReq(iReq), .iRdata(iRd), .iIllegal(iIll), .iArea(iArea), .xReq(xReq), .xRsp(xRsp),
    .highAddressPort(hiPort), .extLowAddr(loAddr), .extRdStrobe(exRs), .extWrStrobe(exWs),
    .extWdata(exWd), .extRdata(exRd));
  xdmm_ext_mem mem (.core_clk(core_clk), .highAddressPort(hiPort), .extLowAddr(loAddr),
    .extRdStrobe(exRs), .extWrStrobe(exWs), .extWdata(exWd), .extRdata(exRd));
  // ==========================================================
  // Shared tasks
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task axi_wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge core_clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge core_clk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid) break;
    end
    bReady <= 1'b0;
    chk("bvalid", 1, bValid);
    chk("bresp", er, bResp);
  endtask : axi_wr
  task axi_chk(input logic [9:0] a, input logic [31:0] e, input logic [31:0] msk, input logic [1:0] er);
    @(posedge core_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge core_clk);
      if (arValid && arReady) arValid <= 1'b0;
      if (rValid) break;
    end
    rReady <= 1'b0;
    chk("rvalid", 1, rValid);
    chk("rresp", er, rResp);
    chk("rdata", e, rData & msk);
  endtask : axi_chk
  task iacc(input logic w, input logic ind, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    iReq <= '{req: 1'b1, write: w, indirect: ind, addr: a, wdata: d};
    #1;
    chk("area", a <= 8'h1F ? xdmm_pkg::XDMM_AREA_WORKREG : a <= 8'h2F ? xdmm_pkg::XDMM_AREA_BIT :
      a <= 8'h7F ? xdmm_pkg::XDMM_AREA_GENERAL : xdmm_pkg::XDMM_AREA_UPPER, iArea);
    chk("illegal", !ind && a > 8'h7F, iIll);
    @(posedge core_clk);
    iReq.req <= 1'b0;
    #1;
    if (!w) chk("iRdata", sp[a], iRd);
    else if (ind || a <= 8'h7F) sp[a] = d;
  endtask : iacc
  task xmove(input logic w, input logic v, input logic [7:0] lo, input logic [7:0] d);
    logic [15:0] a;
    logic in;
    int k;
    int e;
    @(posedge core_clk);
    a = v ? (ptrSel ? dp1 : dp0) : {pg, lo};
    in = !en && (v ? a <= 16'h03FF : pg <= 8'h03);
    k = {v ? a[15:8] : (en ? latch : pg), v ? a[7:0] : lo};
    e = in ? xm[a[9:0]] : (em.exists(k) ? em[k] : 0);
    xReq <= '{req: 1'b1, write: w, viaPointer: v, lowReg: lo, wdata: d};
    @(posedge core_clk);
    xReq.req <= 1'b0;
    #1;
    chk("ack", 1, xRsp.ack);
    chk("rdStrobe", !in && !w, exRs);
    chk("wrStrobe", !in && w, exWs);
    if (!in) chk("extAddr", k, {hiPort, loAddr});
    if (!w && e >= 0) chk("xRdata", e, xRsp.rdata);
    if (w && in) xm[a[9:0]] = d;
    else if (w) em[k] = d;
    axi_chk(xdmm_pkg::STATUS_OFF, {k[15:8], 7'h00, !in}, 32'hFF01, xdmm_pkg::RESP_OKAY);
  endtask : xmove
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // ==========================================================
  // Watchdog
  initial begin
    repeat (60000) @(posedge core_clk);
    errors++;
    print_verdict();
  end
  // Main sequence
  initial begin
    foreach (xm[i]) xm[i] = -1;
    void'($urandom(10));
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    // Reset values and unmapped place
    axi_chk(xdmm_pkg::PAGE_SEL_OFF, 0, 32'hFFFFFFFF, xdmm_pkg::RESP_OKAY);
    axi_chk(xdmm_pkg::CTRL_OFF, 0, 32'hFFFFFFFF, xdmm_pkg::RESP_OKAY);
    axi_chk(10'h040, 0, 32'hFFFFFFFF, xdmm_pkg::RESP_SLVERR);
    axi_wr(10'h040, 32'h1, xdmm_pkg::RESP_SLVERR);
    // Service region for every block count, one beyond the top refused
    for (n = 0; n <= 17; n++) begin
      axi_wr(xdmm_pkg::CTRL_OFF, n << 8, xdmm_pkg::RESP_OKAY);
      nb = n > 16 ? 16 : n;
      axi_chk(xdmm_pkg::CTRL_OFF, nb << 8, 32'h1F00, xdmm_pkg::RESP_OKAY);
      b = 65536 - nb * 256;
      for (m = -1; m <= 0; m++) begin
        @(posedge core_clk);
        progAddr <= 16'((b + m) & 16'hFFFF);
        #1;
        chk("svcHit", nb > 0 && b + m >= b, progHit);
      end
    end
    axi_wr(xdmm_pkg::CTRL_OFF, 0, xdmm_pkg::RESP_OKAY);
    // Scratchpad areas and addressing modes
    foreach (sa[i]) begin
      iacc(1'b1, 1'b1, sa[i], 8'($urandom));
      iacc(1'b1, 1'b0, sa[i], 8'($urandom));
      iacc(1'b0, 1'b0, sa[i], 8'h00);
      iacc(1'b0, 1'b1, sa[i], 8'h00);
    end
    // Random external-data moves over pages, enable and pointer choice
    repeat (120) begin
      pg = ($urandom % 3) ? 8'($urandom % 8) : 8'($urandom);
      en = ($urandom % 4) == 0;
      ptrSel = 1'($urandom);
      axi_wr(xdmm_pkg::PAGE_SEL_OFF, {24'h0, pg}, xdmm_pkg::RESP_OKAY);
      axi_wr(xdmm_pkg::CTRL_OFF, {30'h0, ptrSel, en}, xdmm_pkg::RESP_OKAY);
      dp0 <= {($urandom % 2) ? 8'($urandom % 5) : 8'($urandom), 8'($urandom % 16)};
      dp1 <= {($urandom % 2) ? 8'($urandom % 5) : 8'($urandom), 8'($urandom % 16)};
      latch <= 8'($urandom);
      xmove(1'($urandom), 1'($urandom), 8'($urandom % 16), 8'($urandom));
    end
    // Reset in mid-run puts the registers back to their reset values
    axi_wr(xdmm_pkg::PAGE_SEL_OFF, 32'h0000_00A5, xdmm_pkg::RESP_OKAY);
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    axi_chk(xdmm_pkg::PAGE_SEL_OFF, 0, 32'hFFFFFFFF, xdmm_pkg::RESP_OKAY);
    axi_chk(xdmm_pkg::CTRL_OFF, 0, 32'hFFFFFFFF, xdmm_pkg::RESP_OKAY);
    axi_chk(xdmm_pkg::STATUS_OFF, 0, 32'hFFFFFFFF, xdmm_pkg::RESP_OKAY);
    chk("hiPort", 0, hiPort);
    print_verdict();
  end
endmodule : xdmm_top_test
